// [hw/fcr_clk_div.sv]
// flash timing clock divider: optional divide by eight, then by ratio+1
`timescale 1ns/1ps
`default_nettype none
module fcr_clk_div (
    input wire logic clk, // bus clock
    input wire logic reset, // async, active high
    fcr_div_if.div dv // settings in, tick out
);
    logic [fcr_pkg::PRE_W-1:0] pre_ff;
    logic [fcr_pkg::DIV_W-1:0] cnt_ff;
    logic tick_ff;
    logic pre_tick;

    // prescaler passes every cycle unless divide by eight is chosen
    assign pre_tick = !dv.prescale || (pre_ff == fcr_pkg::PRE_LAST);
    assign dv.tick = tick_ff;

    // =========================================================
    // prescaler
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pre_ff <= '0;
        end else if (!dv.en || pre_ff == fcr_pkg::PRE_LAST) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + 3'h1;
        end
    end

    // =========================================================
    // ratio counter, one tick per ratio+1 prescaled cycles
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_ff <= '0;
        end else if (!dv.en) begin
            cnt_ff <= '0;
        end else if (pre_tick) begin
            if (cnt_ff == dv.ratio) begin
                cnt_ff <= '0;
            end else begin
                cnt_ff <= cnt_ff + 6'h01;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= dv.en && pre_tick && (cnt_ff == dv.ratio);
        end
    end
endmodule
`default_nettype wire

// [hw/fcr_div_if.sv]
// link between the register logic and the flash clock divider
`timescale 1ns/1ps
`default_nettype none
interface fcr_div_if;
    logic en;
    logic prescale;
    logic [fcr_pkg::DIV_W-1:0] ratio;
    logic tick;
    modport ctl (output en, output prescale, output ratio, input tick);
    modport div (input en, input prescale, input ratio, output tick);
endinterface
`default_nettype wire

// [hw/fcr_pkg.sv]
// constants shared by the flash clock ratio and option register logic
package fcr_pkg;
    // register port
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_RATIO = 4'h0;
    localparam logic [3:0] OFF_OPT = 4'h1;
    localparam logic [3:0] OFF_PROT = 4'h2;
    localparam logic [3:0] OFF_KEYCTL = 4'h3;
    localparam logic [3:0] OFF_STAT = 4'h4;
    localparam int KEY_SEL_BIT = 3;
    // clock ratio register
    localparam int RATIO_W = 7;
    localparam int DIV_W = 6;
    localparam int BIT_LOADED = 7;
    localparam int BIT_PRESCALE = 6;
    localparam logic [6:0] RATIO_RST = 7'h00;
    localparam int PRE_W = 3;
    localparam logic [2:0] PRE_LAST = 3'h7;
    localparam logic [9:0] PRE_FACTOR = 10'h008;
    localparam int GAP_W = 10;
    // option register
    localparam int OPT_BACKDOOR_UNLOCK_ENABLE = 7;
    localparam int OPT_NORED = 6;
    localparam logic [1:0] SEC_OPEN = 2'h2;
    localparam logic [7:0] OPT_RST = 8'hff;
    localparam logic [7:0] PROT_RST = 8'hff;
    // key control and status
    localparam int KEYCTL_ACC = 5;
    localparam int STAT_ACCERR = 4;
    localparam int STAT_BUSY = 1;
    localparam int STAT_UNSEC = 0;
    localparam int KEY_BYTES = 8;
    localparam int KEY_IDX_W = 4;
    localparam logic [3:0] KEY_FULL = 4'h8;
    // program and erase pulse counter
    localparam int CNT_W = 8;
endpackage

// [hw/fcr_top.sv]
// flash clock ratio, option, security and timing pulse logic
//
// What this block does
// - Ratio register: bit 7 read-only flag, bits 6:0 readable, written once.
// - Reset clears loaded flag; first ratio write sets it, any data.
// - Program and erase blocked until the loaded flag is set.
// - Prescale bit 6 selects bus clock or bus clock divided by eight.
// - Flash clock is the prescaled clock divided by ratio field plus one.
// - Each timing pulse is one flash clock; the divider is free-running, so an operation's first pulse may come early.
// - At reset the option and protection bytes load from flash.
// - With backdoor enable clear, the key cannot unlock security.
// - Key comparison writes accepted only from secure firmware, not debug.
// - Eight matching key bytes in order unlock until next reset.
// - Redirect-disable bit 6 set stops vector redirection.
// - Security code 1:0 means unsecured; every other code is secure.
// - While secure, unsecured sources and debug cannot reach memory.
// - Key match or full blank check forces security code to 1:0.
// - Five 8-bit control registers plus an eight-byte flash key.
// - Blocked memory writes do nothing; blocked reads return zero.
// - Program or erase before ratio write raises access error, ignored.
`timescale 1ns/1ps
`default_nettype none
module fcr_top (
    input wire logic clk, // bus clock, 100 MHz
    input wire logic reset, // async, active high
    input wire logic [3:0] addr, // register address
    input wire logic [7:0] wr_data, // register write data
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    output logic [7:0] rd_data, // read data, cycle after rd_en
    input wire logic bus_from_secure, // access from secure code
    input wire logic bus_from_bdm, // access from debug port
    input wire logic [7:0] option_nonvolatile_byte, // flash option byte
    input wire logic [7:0] protection_nonvolatile_byte, // flash prot byte
    input wire logic [63:0] backdoor_compare_key, // stored key, byte 0 low
    input wire logic pe_req, // start program or erase, pulse
    input wire logic [7:0] pe_pulses, // timing pulses for the operation
    input wire logic blank_ok, // blank check found all erased, pulse
    output logic pe_enable, // program and erase permitted
    output logic pe_busy, // operation timing in progress
    output logic pe_done, // operation timing finished, pulse
    output logic flash_tick, // one pulse per flash clock period
    input wire logic mem_rd, // memory read request
    input wire logic mem_wr, // memory write request
    input wire logic mem_from_secure, // memory access from secure code
    input wire logic mem_from_bdm, // memory access from debug port
    input wire logic [7:0] mem_rdata_in, // raw memory read data
    output logic mem_rd_allow, // read may proceed
    output logic mem_wr_allow, // write may proceed
    output logic [7:0] mem_rdata, // gated read data, next cycle
    output logic unsecured, // security disengaged
    output logic vector_redirect_enable, // vectors may be redirected
    output logic backdoor_unlock_enable, // key mechanism usable
    output logic [7:0] protection_working_reg, // block protection setting
    output logic access_error_flag // sticky access error
);
    typedef enum logic [1:0] {
        FCR_IDLE = 2'b01,
        FCR_RUN = 2'b10
    } fcr_state_e;

    logic [fcr_pkg::RATIO_W-1:0] ratio_ff;
    logic ratio_loaded_flag;
    logic [7:0] option_working_reg;
    logic [7:0] prot_ff;
    logic load_pending_ff;
    logic key_access_ff;
    logic [fcr_pkg::KEY_IDX_W-1:0] key_idx_ff;
    logic key_bad_ff;
    logic acc_err_ff;
    fcr_state_e state_ff;
    logic [fcr_pkg::CNT_W-1:0] left_ff;
    logic done_ff;
    logic [7:0] rd_data_ff;
    logic [7:0] mem_rdata_ff;
    logic wr_ratio;
    logic wr_keyctl;
    logic wr_key;
    logic key_src_ok;
    logic key_hit;
    logic mem_blocked;
    logic [7:0] key_byte;
    fcr_div_if dv ();

    // =========================================================
    // decode
    assign wr_ratio = wr_en && addr == fcr_pkg::OFF_RATIO;
    assign wr_keyctl = wr_en && addr == fcr_pkg::OFF_KEYCTL;
    assign key_src_ok = bus_from_secure && !bus_from_bdm;
    assign wr_key = wr_en && addr[fcr_pkg::KEY_SEL_BIT] && key_access_ff
        && key_src_ok;
    assign key_byte = backdoor_compare_key[key_idx_ff[2:0]*8 +: 8];
    // unlock when key access closes after a clean full sequence
    assign key_hit = wr_keyctl && key_access_ff
        && !wr_data[fcr_pkg::KEYCTL_ACC] && key_src_ok
        && option_working_reg[fcr_pkg::OPT_BACKDOOR_UNLOCK_ENABLE]
        && !key_bad_ff && key_idx_ff == fcr_pkg::KEY_FULL;

    // =========================================================
    // clock ratio register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ratio_ff <= fcr_pkg::RATIO_RST;
            ratio_loaded_flag <= 1'b0;
        end else if (wr_ratio && !ratio_loaded_flag) begin
            ratio_ff <= wr_data[fcr_pkg::RATIO_W-1:0];
            ratio_loaded_flag <= 1'b1;
        end
    end

    // divider runs only once the ratio has been written
    assign dv.en = ratio_loaded_flag;
    assign dv.prescale = ratio_ff[fcr_pkg::BIT_PRESCALE];
    assign dv.ratio = ratio_ff[fcr_pkg::DIV_W-1:0];
    assign flash_tick = dv.tick;
    assign pe_enable = ratio_loaded_flag;

    fcr_clk_div u_div (
        .clk(clk),
        .reset(reset),
        .dv(dv)
    );

    // =========================================================
    // option and protection working registers
    // the nonvolatile bytes are caught on the first edge after release,
    // since an async reset may only load constants
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            load_pending_ff <= 1'b1;
            option_working_reg <= fcr_pkg::OPT_RST;
            prot_ff <= fcr_pkg::PROT_RST;
        end else if (load_pending_ff) begin
            load_pending_ff <= 1'b0;
            option_working_reg <= option_nonvolatile_byte;
            prot_ff <= protection_nonvolatile_byte;
        end else if (key_hit || blank_ok) begin
            option_working_reg[1:0] <= fcr_pkg::SEC_OPEN;
        end
    end

    assign protection_working_reg = prot_ff;
    assign unsecured = option_working_reg[1:0] == fcr_pkg::SEC_OPEN;
    assign vector_redirect_enable =
        !option_working_reg[fcr_pkg::OPT_NORED];
    assign backdoor_unlock_enable = option_working_reg[fcr_pkg::OPT_BACKDOOR_UNLOCK_ENABLE];

    // =========================================================
    // backdoor key comparison
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            key_access_ff <= 1'b0;
        end else if (wr_keyctl && key_src_ok) begin
            key_access_ff <= wr_data[fcr_pkg::KEYCTL_ACC];
        end
    end

    // bytes must arrive in ascending order; any slip spoils the attempt
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            key_idx_ff <= '0;
            key_bad_ff <= 1'b0;
        end else if (!key_access_ff) begin
            key_idx_ff <= '0;
            key_bad_ff <= 1'b0;
        end else if (wr_key) begin
            if (key_idx_ff == fcr_pkg::KEY_FULL
                || addr[2:0] != key_idx_ff[2:0]
                || wr_data != key_byte) begin
                key_bad_ff <= 1'b1;
            end
            if (key_idx_ff != fcr_pkg::KEY_FULL) begin
                key_idx_ff <= key_idx_ff + 4'h1;
            end
        end
    end

    // =========================================================
    // program and erase timing
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            acc_err_ff <= 1'b0;
        end else if (pe_req && !ratio_loaded_flag) begin
            acc_err_ff <= 1'b1; // set wins over clear
        end else if (wr_en && addr == fcr_pkg::OFF_STAT
                     && wr_data[fcr_pkg::STAT_ACCERR]) begin
            acc_err_ff <= 1'b0;
        end
    end
    assign access_error_flag = acc_err_ff;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= FCR_IDLE;
            left_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            unique case (state_ff)
                FCR_IDLE: begin
                    // a zero count has nothing to time
                    if (pe_req && ratio_loaded_flag && pe_pulses != '0) begin
                        state_ff <= FCR_RUN;
                        left_ff <= pe_pulses;
                    end
                end
                FCR_RUN: begin
                    if (dv.tick) begin
                        left_ff <= left_ff - 8'h01;
                        if (left_ff == 8'h01) begin
                            state_ff <= FCR_IDLE;
                            done_ff <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end
    assign pe_busy = state_ff == FCR_RUN;
    assign pe_done = done_ff;

    // =========================================================
    // memory access gate
    assign mem_blocked = !unsecured
        && (!mem_from_secure || mem_from_bdm);
    assign mem_rd_allow = mem_rd && !mem_blocked;
    assign mem_wr_allow = mem_wr && !mem_blocked;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mem_rdata_ff <= '0;
        end else if (mem_rd) begin
            mem_rdata_ff <= mem_blocked ? '0 : mem_rdata_in;
        end
    end
    assign mem_rdata = mem_rdata_ff;

    // =========================================================
    // register read port; key locations read as zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_data_ff <= '0;
        end else if (rd_en) begin
            unique case (addr)
                fcr_pkg::OFF_RATIO: rd_data_ff <= {ratio_loaded_flag,
                    ratio_ff};
                fcr_pkg::OFF_OPT: rd_data_ff <= option_working_reg;
                fcr_pkg::OFF_PROT: rd_data_ff <= prot_ff;
                fcr_pkg::OFF_KEYCTL: rd_data_ff <=
                    8'(key_access_ff) << fcr_pkg::KEYCTL_ACC;
                fcr_pkg::OFF_STAT: rd_data_ff <=
                    (8'(acc_err_ff) << fcr_pkg::STAT_ACCERR)
                    | (8'(pe_busy) << fcr_pkg::STAT_BUSY)
                    | (8'(unsecured) << fcr_pkg::STAT_UNSEC);
                default: rd_data_ff <= '0;
            endcase
        end
    end
    assign rd_data = rd_data_ff;

    // =========================================================
    // checks
    logic [fcr_pkg::GAP_W-1:0] gap_ff;
    logic seen_ff;
    logic [fcr_pkg::GAP_W-1:0] period;
    assign period = (dv.prescale ? fcr_pkg::PRE_FACTOR : 10'h001)
        * (10'(dv.ratio) + 10'h001);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gap_ff <= '0;
            seen_ff <= 1'b0;
        end else if (dv.tick) begin
            gap_ff <= '0;
            seen_ff <= 1'b1;
        end else begin
            gap_ff <= gap_ff + 10'h001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_ratio_once: assert property (
        wr_ratio && ratio_loaded_flag |=> $stable(ratio_ff)
            && ratio_loaded_flag)
        else $error("ratio register changed on a second write");
    a_loaded_set: assert property (
        wr_ratio && !ratio_loaded_flag |=> ratio_loaded_flag
            && ratio_ff == $past(wr_data[fcr_pkg::RATIO_W-1:0]))
        else $error("first ratio write not taken");
    a_pe_blocked: assert property (
        pe_req && !ratio_loaded_flag |=> acc_err_ff && !pe_busy)
        else $error("operation before ratio write not refused");
    a_tick_period: assert property (
        dv.tick && seen_ff |-> gap_ff == period - 10'h001)
        else $error("flash tick period wrong");
    a_pulse_count: assert property (
        pe_busy && dv.tick && left_ff == 8'h01 |=> pe_done && !pe_busy)
        else $error("operation did not end on its last pulse");
    a_sec_force: assert property (
        blank_ok && !load_pending_ff |=> unsecured)
        else $error("blank check did not unsecure");
    a_key_gated: assert property (
        !unsecured && !blank_ok && !load_pending_ff
            && (!backdoor_unlock_enable || !key_src_ok) |=> !unsecured)
        else $error("security dropped without a permitted unlock");
    a_block_read: assert property (
        mem_rd && mem_blocked |-> !mem_rd_allow && !mem_wr_allow
            ##1 mem_rdata == 8'h00)
        else $error("blocked read returned data");
    a_opt_ro: assert property (
        wr_en && addr == fcr_pkg::OFF_OPT && !load_pending_ff
            && !blank_ok && !key_hit |=> $stable(option_working_reg))
        else $error("option register changed by a write");
    a_redirect: assert property (
        load_pending_ff |=> vector_redirect_enable
            == !$past(option_nonvolatile_byte[fcr_pkg::OPT_NORED]))
        else $error("redirect output disagrees with option bit");

    c_tick: cover property (dv.tick ##[1:600] dv.tick);
    c_unlock: cover property (key_hit ##1 unsecured);
    c_acc_err: cover property (pe_req && !ratio_loaded_flag);
    c_run_done: cover property (pe_busy ##[1:1000] pe_done);
endmodule
`default_nettype wire

// [verification/fcr_top_tb.sv]
// self-checking bench for the flash clock ratio and option register logic
`timescale 1ns/1ps
`default_nettype none
module fcr_top_tb;
    // arbitrary stored key, byte 0 in the low bits
    localparam logic [63:0] KEY = 64'h8877665544332211;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rd_data;
    logic bus_from_secure = 1'b1;
    logic bus_from_bdm = 1'b0;
    logic [7:0] opt_nv = 8'hff;
    logic [7:0] prot_nv = 8'hf8;
    logic pe_req = 1'b0;
    logic [7:0] pe_pulses = 8'h00;
    logic blank_ok = 1'b0;
    logic pe_enable, pe_busy, pe_done, flash_tick;
    logic mem_rd = 1'b0;
    logic mem_wr = 1'b0;
    logic mem_from_secure = 1'b0;
    logic mem_from_bdm = 1'b1;
    logic [7:0] mem_rdata_in = 8'h5a;
    logic mem_rd_allow, mem_wr_allow, unsecured, vector_redirect_enable;
    logic backdoor_unlock_enable, access_error_flag;
    logic [7:0] mem_rdata, protection_working_reg;
    logic [7:0] d;
    int n_mismatch = 0;
    int n_compared = 0;

    always #5 clk = ~clk;

    fcr_top fcr_top_i (
        .clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .bus_from_secure(bus_from_secure), .bus_from_bdm(bus_from_bdm),
        .option_nonvolatile_byte(opt_nv),
        .protection_nonvolatile_byte(prot_nv),
        .backdoor_compare_key(KEY), .pe_req(pe_req), .pe_pulses(pe_pulses),
        .blank_ok(blank_ok), .pe_enable(pe_enable), .pe_busy(pe_busy),
        .pe_done(pe_done), .flash_tick(flash_tick), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_from_secure(mem_from_secure),
        .mem_from_bdm(mem_from_bdm), .mem_rdata_in(mem_rdata_in),
        .mem_rd_allow(mem_rd_allow), .mem_wr_allow(mem_wr_allow),
        .mem_rdata(mem_rdata), .unsecured(unsecured),
        .vector_redirect_enable(vector_redirect_enable),
        .backdoor_unlock_enable(backdoor_unlock_enable),
        .protection_working_reg(protection_working_reg),
        .access_error_flag(access_error_flag)
    );

    // ==========================================================
    // checking and closing
    task automatic chk8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_cnt(input string nm, input int e, input int g);
        n_compared++;
        if (g != e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==========================================================
    // bus and stimulus helpers
    task automatic do_reset(input logic [7:0] opt);
        @(posedge clk);
        reset <= 1'b1;
        opt_nv <= opt;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        v = rd_data;
    endtask

    // one gated memory read and write from the debug port
    task automatic mem_chk(input logic allow, input logic [7:0] e);
        @(posedge clk);
        mem_rd <= 1'b1;
        mem_wr <= 1'b1;
        @(posedge clk);
        #1;
        chk1("mem_rd_allow", allow, mem_rd_allow);
        chk1("mem_wr_allow", allow, mem_wr_allow);
        chk8("mem_rdata", e, mem_rdata);
        @(posedge clk);
        mem_rd <= 1'b0;
        mem_wr <= 1'b0;
    endtask

    // key entry; a bad try spoils byte 5
    task automatic key_try(input logic sec, input logic background_debug_mode, input logic bad);
        @(posedge clk);
        bus_from_secure <= sec;
        bus_from_bdm <= background_debug_mode;
        wr(fcr_pkg::OFF_KEYCTL, 8'h20);
        for (int i = 0; i < 8; i++) begin
            wr(4'h8 + 4'(i), KEY[8*i +: 8] ^ ((bad && i == 5) ? 8'h01 : 8'h00));
        end
        wr(fcr_pkg::OFF_KEYCTL, 8'h00);
        bus_from_secure <= 1'b1;
        bus_from_bdm <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic tick_gap(input int e);
        int n;
        n = 0;
        while (flash_tick !== 1'b1 && n < 600) begin
            @(posedge clk);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (flash_tick !== 1'b1 && n < 600);
        chk_cnt("tick period", e, n);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_decode();
        for (int sc = 0; sc < 4; sc++) begin
            do_reset(8'h80 | 8'(sc));
            rd(fcr_pkg::OFF_OPT, d);
            chk8("option", 8'h80 | 8'(sc), d);
            chk8("protection", prot_nv, protection_working_reg);
            chk1("unsecured", sc == 2, unsecured);
            chk1("redirect", 1'b1, vector_redirect_enable);
            chk1("unlock enable", 1'b1, backdoor_unlock_enable);
        end
    endtask

    task automatic t_unloaded();
        do_reset(8'h43);
        chk1("redirect", 1'b0, vector_redirect_enable);
        chk1("unlock enable", 1'b0, backdoor_unlock_enable);
        rd(fcr_pkg::OFF_RATIO, d);
        chk8("ratio reset", 8'h00, d);
        chk1("pe_enable", 1'b0, pe_enable);
        @(posedge clk);
        pe_req <= 1'b1;
        pe_pulses <= 8'h02;
        @(posedge clk);
        pe_req <= 1'b0;
        #1;
        chk1("access error", 1'b1, access_error_flag);
        chk1("busy", 1'b0, pe_busy);
        rd(fcr_pkg::OFF_STAT, d);
        chk1("status error", 1'b1, d[fcr_pkg::STAT_ACCERR]);
        wr(fcr_pkg::OFF_STAT, 8'h10);
        rd(fcr_pkg::OFF_STAT, d);
        chk1("error cleared", 1'b0, d[fcr_pkg::STAT_ACCERR]);
        key_try(1'b1, 1'b0, 1'b0);
        chk1("key when disabled", 1'b0, unsecured);
        mem_chk(1'b0, 8'h00);
        @(posedge clk);
        blank_ok <= 1'b1;
        @(posedge clk);
        blank_ok <= 1'b0;
        #1;
        chk1("blank unlock", 1'b1, unsecured);
        mem_chk(1'b1, 8'h5a);
    endtask

    task automatic t_ratio(input logic [7:0] v, input int gap);
        do_reset(8'h82);
        wr(fcr_pkg::OFF_RATIO, v);
        rd(fcr_pkg::OFF_RATIO, d);
        chk8("ratio", v | 8'h80, d);
        chk1("pe_enable", 1'b1, pe_enable);
        wr(fcr_pkg::OFF_RATIO, ~v & 8'h7f);
        rd(fcr_pkg::OFF_RATIO, d);
        chk8("ratio rewrite", v | 8'h80, d);
        wr(fcr_pkg::OFF_OPT, 8'h00);
        // a new flash byte without a reset must not reach the register
        opt_nv <= 8'h00;
        rd(fcr_pkg::OFF_OPT, d);
        chk8("option write", 8'h82, d);
        rd(4'h5, d);
        chk8("unmapped", 8'h00, d);
        tick_gap(gap);
    endtask

    task automatic t_run();
        int ticks;
        int last;
        int cyc;
        ticks = 0;
        last = 0;
        cyc = 0;
        @(posedge clk);
        pe_req <= 1'b1;
        pe_pulses <= 8'h03;
        @(posedge clk);
        pe_req <= 1'b0;
        #1;
        chk1("busy", 1'b1, pe_busy);
        while (pe_done !== 1'b1 && cyc < 2000) begin
            if (flash_tick === 1'b1) begin
                ticks++;
                last = cyc;
            end
            @(posedge clk);
            #1;
            cyc++;
        end
        chk_cnt("ticks", 3, ticks);
        chk_cnt("done cycle", last + 1, cyc);
        chk1("busy end", 1'b0, pe_busy);
        @(posedge clk);
        #1;
        chk1("done pulse", 1'b0, pe_done);
    endtask

    task automatic t_backdoor();
        do_reset(8'h83);
        mem_chk(1'b0, 8'h00);
        key_try(1'b1, 1'b1, 1'b0);
        chk1("debug key", 1'b0, unsecured);
        key_try(1'b1, 1'b0, 1'b1);
        chk1("wrong key", 1'b0, unsecured);
        key_try(1'b1, 1'b0, 1'b0);
        chk1("good key", 1'b1, unsecured);
        rd(fcr_pkg::OFF_OPT, d);
        chk8("option code", 8'h82, d);
        mem_chk(1'b1, 8'h5a);
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        // generous bound: the whole sequence needs a few thousand cycles
        #200000;
        n_mismatch++;
        complete_run();
    end

    initial begin
        do_reset(8'hff);
        t_decode();
        t_unloaded();
        t_ratio(8'h4c, 104);
        t_ratio(8'h03, 4);
        // 100 MHz / (8 * 64) gives about 195 kHz before any operation
        t_ratio(8'h7f, 512);
        t_run();
        t_backdoor();
        complete_run();
    end
endmodule
`default_nettype wire
